//--- design/uohc_consts.svh
// Register offsets, field positions, reset values and timing counts of the host control block
`ifndef UOHC_CONSTS_SVH
`define UOHC_CONSTS_SVH

`define UOHC_OFF_CTRL 12'h000
`define UOHC_OFF_ADDR 12'h004
`define UOHC_OFF_IRQ_STAT 12'h008
`define UOHC_OFF_IRQ_MASK 12'h00C
`define UOHC_OFF_MODE 12'h010
`define UOHC_OFF_LINK 12'h014

`define UOHC_CTRL_FRAME_EN 0
`define UOHC_CTRL_PP_CLR 1
`define UOHC_CTRL_RESUME 2
`define UOHC_CTRL_HOST_EN 3
`define UOHC_CTRL_BUS_RST 4
`define UOHC_CTRL_TOK_BUSY 5
`define UOHC_CTRL_SE0 6
`define UOHC_CTRL_IDLE_J 7

`define UOHC_ADDR_SLOW 7
`define UOHC_ADDR_W 7

`define UOHC_IRQ_FRAME 0
`define UOHC_IRQ_SE0 1
`define UOHC_IRQ_TOK_DONE 2
`define UOHC_IRQ_W 3

`define UOHC_RESET_CTRL 16'h0000
`define UOHC_RESET_ADDR 16'h0000

`define UOHC_CLK_HZ 40000000
`define UOHC_FRAME_US 1000
`define UOHC_FRAME_CYCLES ((`UOHC_CLK_HZ / 1000000) * `UOHC_FRAME_US)
`define UOHC_FRAME_CNT_W 16

`endif

//--- design/uohc_pkg.sv
// Types shared by the host control block
package uohc_pkg;
  typedef enum logic [1:0] {
    UOHC_LINE_IDLE = 2'b00,
    UOHC_LINE_RESET = 2'b01,
    UOHC_LINE_RESUME = 2'b10
  } uohc_line_t;
endpackage

//--- design/uohc_frame_timer.sv
// Millisecond frame tick generator
`timescale 1ns/1ps
`default_nettype none
`include "uohc_consts.svh"

module uohc_frame_timer #(
  parameter int FRAME_CYCLES = `UOHC_FRAME_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  output logic tick
);
  logic [`UOHC_FRAME_CNT_W-1:0] count;
  logic [`UOHC_FRAME_CNT_W-1:0] next_count;
  logic next_tick;
  localparam logic [`UOHC_FRAME_CNT_W-1:0] LAST = `UOHC_FRAME_CNT_W'(FRAME_CYCLES - 1);

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (!enable) begin
      // Restarting from zero gives a full frame before the first marker
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

//--- design/uohc_top.sv
// Host mode control and address registers of the USB link, APB slave
// Notes on behaviour
// - SE0 flag reads 1 live whenever both data lines sit low.
// - Token-busy flag is high while a token executes in the host role, low otherwise.
// - Bus-reset bit drives USB reset in the host role only; software times it to 50 ms.
// - Host-enable bit enables host role and both D+ and D- pull-downs.
// - Resume bit drives resume signalling in the host role unless bus reset is set; software holds it 10 ms.
// - Writing 1 to ping-pong clear returns pointers to even bank; 0 does nothing.
// - Slow-rate bit 1 selects low speed, 0 selects full speed.
// - Slow-rate bit exists only in host mode, else reads 0.
// - Address register holds a seven-bit device address in bits 6..0.
`timescale 1ns/1ps
`default_nettype none
`include "uohc_consts.svh"

module uohc_top
  import uohc_pkg::*;
#(
  parameter int FRAME_CYCLES = `UOHC_FRAME_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic token_active,
  output logic dp_out,
  output logic dm_out,
  output logic dp_oe_n,
  output logic dm_oe_n,
  output logic pulldown_en,
  output logic host_role,
  output logic slow_rate,
  output logic pingpong_clear,
  output logic frame_marker,
  output logic [6:0] device_address,
  output logic irq
);

  // ---------------------------------------------------------------
  // Line input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic tok_meta;
  logic tok_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta <= 2'b00;
      line_sync <= 2'b00;
      tok_meta <= 1'b0;
      tok_sync <= 1'b0;
    end else begin
      line_meta <= {dp_in, dm_in};
      line_sync <= line_meta;
      tok_meta <= token_active;
      tok_sync <= tok_meta;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic frame_marker_enable;
  logic bus_reset_drive;
  logic host_role_enable;
  logic resume_drive;
  logic slow_rate_select;
  logic [6:0] dev_addr;
  logic [`UOHC_IRQ_W-1:0] irq_status;
  logic [`UOHC_IRQ_W-1:0] irq_mask;
  logic token_in_progress_flag;
  logic se0_flag;
  logic idle_line_level_flag;
  logic tok_prev;
  logic se0_prev;
  logic pp_pulse;
  logic [31:0] rdata_q;
  logic ready_q;
  logic err_q;

  logic next_frame_marker_enable;
  logic next_bus_reset_drive;
  logic next_host_role_enable;
  logic next_resume_drive;
  logic next_slow_rate_select;
  logic [6:0] next_dev_addr;
  logic [`UOHC_IRQ_W-1:0] next_irq_status;
  logic [`UOHC_IRQ_W-1:0] next_irq_mask;
  logic next_pp_pulse;
  logic [31:0] next_rdata_q;
  logic next_ready_q;
  logic next_err_q;

  logic frame_tick;
  logic setup;
  logic wr;
  logic rd;
  logic [`UOHC_IRQ_W-1:0] events;
  uohc_line_t line_mode;
  logic low_speed;
  logic next_token_in_progress_flag;
  logic next_slow_rate;
  logic next_irq;

  // ---------------------------------------------------------------
  // APB access decode
  // ---------------------------------------------------------------
  // No wait state per access: setup captured, answer next cycle
  assign setup = psel && !penable;
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;

  // ---------------------------------------------------------------
  // Live line state
  // ---------------------------------------------------------------
  // Speed choice only counts in the host role; the device side stays at full speed
  assign low_speed = slow_rate_select && host_role_enable;

  // J polarity flips with the chosen speed
  assign se0_flag = (line_sync == 2'b00);
  assign idle_line_level_flag = low_speed ? (line_sync == 2'b01)
                                          : (line_sync == 2'b10);

  // ---------------------------------------------------------------
  // Frame timer
  // ---------------------------------------------------------------
  uohc_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .enable(frame_marker_enable && host_role_enable),
    .tick(frame_tick)
  );

  // ---------------------------------------------------------------
  // Events and register file
  // ---------------------------------------------------------------
  // Events: frame marker, SE0 onset, token completion
  always_comb begin
    events = '0;
    events[`UOHC_IRQ_FRAME] = frame_tick;
    events[`UOHC_IRQ_SE0] = se0_flag && !se0_prev;
    events[`UOHC_IRQ_TOK_DONE] = tok_prev && !token_in_progress_flag;
  end

  always_comb begin
    next_frame_marker_enable = frame_marker_enable;
    next_bus_reset_drive = bus_reset_drive;
    next_host_role_enable = host_role_enable;
    next_resume_drive = resume_drive;
    next_slow_rate_select = slow_rate_select;
    next_dev_addr = dev_addr;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_pp_pulse = 1'b0;
    next_rdata_q = 32'h0000_0000;
    next_ready_q = 1'b0;
    next_err_q = 1'b0;
    if (setup) begin
      next_ready_q = 1'b1;
      case (paddr)
        `UOHC_OFF_CTRL: begin
          if (wr) begin
            next_frame_marker_enable = pwdata[`UOHC_CTRL_FRAME_EN];
            next_pp_pulse = pwdata[`UOHC_CTRL_PP_CLR];
            next_resume_drive = pwdata[`UOHC_CTRL_RESUME];
            next_host_role_enable = pwdata[`UOHC_CTRL_HOST_EN];
            next_bus_reset_drive = pwdata[`UOHC_CTRL_BUS_RST];
          end else begin
            next_rdata_q[`UOHC_CTRL_FRAME_EN] = frame_marker_enable;
            next_rdata_q[`UOHC_CTRL_RESUME] = resume_drive;
            next_rdata_q[`UOHC_CTRL_HOST_EN] = host_role_enable;
            next_rdata_q[`UOHC_CTRL_BUS_RST] = bus_reset_drive;
            next_rdata_q[`UOHC_CTRL_TOK_BUSY] = token_in_progress_flag;
            next_rdata_q[`UOHC_CTRL_SE0] = se0_flag;
            next_rdata_q[`UOHC_CTRL_IDLE_J] = idle_line_level_flag;
          end
        end
        `UOHC_OFF_ADDR: begin
          if (wr) begin
            next_dev_addr = pwdata[`UOHC_ADDR_W-1:0];
            next_slow_rate_select = pwdata[`UOHC_ADDR_SLOW];
          end else begin
            next_rdata_q[`UOHC_ADDR_W-1:0] = dev_addr;
            next_rdata_q[`UOHC_ADDR_SLOW] = slow_rate_select && host_role_enable;
          end
        end
        `UOHC_OFF_IRQ_STAT: begin
          if (rd) begin
            next_rdata_q[`UOHC_IRQ_W-1:0] = irq_status;
            next_irq_status = '0;
          end
        end
        `UOHC_OFF_IRQ_MASK: begin
          if (wr) begin
            next_irq_mask = pwdata[`UOHC_IRQ_W-1:0];
          end else begin
            next_rdata_q[`UOHC_IRQ_W-1:0] = irq_mask;
          end
        end
        default: begin
          next_err_q = 1'b1;
        end
      endcase
    end
    // Set wins over read-clear so an event on the clearing read is kept
    next_irq_status = next_irq_status | events;
  end

  // ---------------------------------------------------------------
  // Line drive
  // ---------------------------------------------------------------
  // Line drive: reset shows SE0, resume shows K (opposite of J)
  always_comb begin
    if (!host_role_enable) begin
      line_mode = UOHC_LINE_IDLE;
    end else if (bus_reset_drive) begin
      line_mode = UOHC_LINE_RESET;
    end else if (resume_drive) begin
      line_mode = UOHC_LINE_RESUME;
    end else begin
      line_mode = UOHC_LINE_IDLE;
    end
  end

  logic next_dp;
  logic next_dm;
  logic next_oe_n;

  always_comb begin
    next_dp = 1'b0;
    next_dm = 1'b0;
    next_oe_n = 1'b1;
    case (line_mode)
      UOHC_LINE_RESET: begin
        next_oe_n = 1'b0;
      end
      UOHC_LINE_RESUME: begin
        next_oe_n = 1'b0;
        next_dp = slow_rate_select ? 1'b0 : 1'b0 | slow_rate_select;
        next_dm = !slow_rate_select;
        if (slow_rate_select) begin
          next_dp = 1'b1;
          next_dm = 1'b0;
        end
      end
      default: begin
        next_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_marker_enable <= 1'b0;
      bus_reset_drive <= 1'b0;
      host_role_enable <= 1'b0;
      resume_drive <= 1'b0;
      slow_rate_select <= 1'b0;
      dev_addr <= 7'h00;
      irq_status <= '0;
      irq_mask <= '0;
      pp_pulse <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      token_in_progress_flag <= 1'b0;
      tok_prev <= 1'b0;
      // Synchronisers reset to SE0, so a low here would fake an onset
      se0_prev <= 1'b1;
    end else begin
      frame_marker_enable <= next_frame_marker_enable;
      bus_reset_drive <= next_bus_reset_drive;
      host_role_enable <= next_host_role_enable;
      resume_drive <= next_resume_drive;
      slow_rate_select <= next_slow_rate_select;
      dev_addr <= next_dev_addr;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      pp_pulse <= next_pp_pulse;
      rdata_q <= next_rdata_q;
      ready_q <= next_ready_q;
      err_q <= next_err_q;
      token_in_progress_flag <= next_token_in_progress_flag;
      tok_prev <= token_in_progress_flag;
      se0_prev <= se0_flag;
    end
  end

  // Next values of flags and pins that combine more than one register
  always_comb begin
    // Token busy only counts while the host role is on
    next_token_in_progress_flag = tok_sync && host_role_enable;
    next_slow_rate = low_speed;
    next_irq = |(irq_status & irq_mask);
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      dp_oe_n <= 1'b1;
      dm_oe_n <= 1'b1;
      pulldown_en <= 1'b0;
      host_role <= 1'b0;
      slow_rate <= 1'b0;
      pingpong_clear <= 1'b0;
      frame_marker <= 1'b0;
      device_address <= 7'h00;
      irq <= 1'b0;
    end else begin
      dp_out <= next_dp;
      dm_out <= next_dm;
      dp_oe_n <= next_oe_n;
      dm_oe_n <= next_oe_n;
      pulldown_en <= host_role_enable;
      host_role <= host_role_enable;
      slow_rate <= next_slow_rate;
      pingpong_clear <= pp_pulse;
      frame_marker <= frame_tick;
      device_address <= dev_addr;
      irq <= next_irq;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

endmodule
`default_nettype wire

//--- test/uohc_sva.sv
// Assertion checker for the host control block
`timescale 1ns/1ps
`default_nettype none
module uohc_sva #(
  parameter int FRAME_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dp_out,
  input wire logic dm_out,
  input wire logic dp_oe_n,
  input wire logic dm_oe_n,
  input wire logic pulldown_en,
  input wire logic host_role,
  input wire logic slow_rate,
  input wire logic pingpong_clear,
  input wire logic frame_marker
);
  logic pp_req;
  logic seen;
  logic [15:0] gap;
  assign pp_req = psel && !penable && pwrite && paddr == 12'h000 && pwdata[1];
  // Gap is only judged from the second marker on: the first one follows enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap <= frame_marker ? 16'h0000 : gap + 16'h0001;
      seen <= seen || frame_marker;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_unmapped_error: assert property (psel && !penable && paddr > 12'h014 |=> pslverr)
    else $error("unmapped access not refused");
  a_pulldown_host: assert property (pulldown_en == host_role)
    else $error("pull-downs differ from host role");
  a_slow_host_only: assert property (slow_rate |-> host_role)
    else $error("slow rate outside host role");
  a_drive_host_only: assert property (!dp_oe_n || !dm_oe_n |-> host_role && dp_oe_n == dm_oe_n
    && !(dp_out && dm_out))
    else $error("bad line drive");
  a_pp_cause: assert property (pp_req |-> ##2 pingpong_clear)
    else $error("pointer clear pulse missing");
  a_pp_quiet: assert property (pingpong_clear |-> $past(pp_req, 2))
    else $error("pointer clear without request");
  a_frame_gap: assert property (frame_marker && seen |-> gap == 16'(FRAME_CYCLES - 1))
    else $error("frame spacing wrong");
  a_frame_host: assert property (frame_marker |-> host_role)
    else $error("frame marker outside host role");
endmodule
bind uohc_top uohc_sva #(.FRAME_CYCLES(FRAME_CYCLES)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_out(dp_out), .dm_out(dm_out),
  .dp_oe_n(dp_oe_n), .dm_oe_n(dm_oe_n), .pulldown_en(pulldown_en), .host_role(host_role),
  .slow_rate(slow_rate), .pingpong_clear(pingpong_clear), .frame_marker(frame_marker));
`default_nettype wire

//--- test/uohc_peer.sv
// Attached peripheral as seen on the data lines
`timescale 1ns/1ps
`default_nettype none
module uohc_peer (
  input wire logic dp_out,
  input wire logic dm_out,
  input wire logic dp_oe_n,
  input wire logic dm_oe_n,
  input wire logic slow_rate,
  input wire logic se0_req,
  output logic dp,
  output logic dm
);
  // Host drive wins; else the peer pull-up gives J, D+ at full speed, D- at low speed
  always_comb begin
    dp = dp_oe_n ? (!se0_req && !slow_rate) : dp_out;
    dm = dm_oe_n ? (!se0_req && slow_rate) : dm_out;
  end
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the host control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic tok = 1'b0;
  logic se0_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] lfsr = 32'hf3c5_18d7;
  logic pready, pslverr, dp, dm, dp_out, dm_out, dp_oe_n, dm_oe_n, irq;
  logic pulldown_en, host_role, slow_rate, pingpong_clear, frame_marker;
  logic [6:0] device_address;
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int k;
  always #12.5 pclk = ~pclk;
  uohc_top #(.FRAME_CYCLES(FC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dp_in(dp), .dm_in(dm), .token_active(tok),
    .dp_out(dp_out), .dm_out(dm_out), .dp_oe_n(dp_oe_n), .dm_oe_n(dm_oe_n),
    .pulldown_en(pulldown_en), .host_role(host_role), .slow_rate(slow_rate),
    .pingpong_clear(pingpong_clear), .frame_marker(frame_marker),
    .device_address(device_address), .irq(irq));
  uohc_peer peer (.dp_out(dp_out), .dm_out(dm_out), .dp_oe_n(dp_oe_n), .dm_oe_n(dm_oe_n),
    .slow_rate(slow_rate), .se0_req(se0_req), .dp(dp), .dm(dm));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pins as {dp_oe_n, dm_oe_n, dp_out, dm_out, pulldown_en, host_role, slow_rate, irq}
  task automatic chk_pin(input logic [7:0] exp);
    @(negedge pclk);
    cmp_pin({dp_oe_n, dm_oe_n, dp_out, dm_out, pulldown_en, host_role, slow_rate, irq}, exp);
  endtask
  task automatic wait_hi(input logic [1:0] s, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((s == 2'd0 ? pready : s == 2'd1 ? frame_marker : irq) !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(2'd0, n);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({a > 12'h014, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (15) @(posedge pclk);
    chk_pin(8'hc0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      apb(1'b1, 12'h004, lfsr);
      rd(12'h004, {25'h0, lfsr[6:0]});
      @(negedge pclk);
      cmp_pin({1'b0, device_address}, {1'b0, lfsr[6:0]});
    end
    rd(12'h018, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    chk_pin(8'hcc);
    apb(1'b1, 12'h004, 32'h0000_0085);
    rd(12'h004, 32'h0000_0085);
    chk_pin(8'hce);
    apb(1'b1, 12'h000, 32'h0000_000c);
    chk_pin(8'h2e);
    apb(1'b1, 12'h004, 32'h0000_0005);
    chk_pin(8'h1c);
    apb(1'b1, 12'h000, 32'h0000_0018);
    chk_pin(8'h0c);
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_0058);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0000_0008);
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_0088);
    se0_req <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_0048);
    se0_req <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_000a);
    @(negedge pclk);
    cmp_pin({7'h00, pingpong_clear}, 8'h01);
    @(negedge pclk);
    cmp_pin({7'h00, pingpong_clear}, 8'h00);
    rd(12'h000, 32'h0000_0088);
    tok <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_00a8);
    tok <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h0000_0088);
    rd(12'h008, 32'h0000_0006);
    rd(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h00c, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0009);
    wait_hi(2'd1, k);
    wait_hi(2'd1, k);
    cmp_pin(8'(k), 8'(FC));
    wait_hi(2'd2, k);
    rd(12'h008, 32'h0000_0001);
    apb(1'b1, 12'h00c, 32'h0000_0000);
    chk_pin(8'hcc);
    close_out();
  end
endmodule
`default_nettype wire
